// file: boot_sel_regs.vh
// Constants shared by the boot mode selector files
`ifndef BOOT_SEL_REGS_VH
`define BOOT_SEL_REGS_VH
// Captured boot pin pair codes (high pin, low pin)
`define BOOT_PAIR_USER 2'h3
`define BOOT_PAIR_STD 2'h2
`define BOOT_PAIR_SEL 2'h1
`define BOOT_PAIR_RSVD 2'h0
// Boot mode codes shown on the mode output
`define MODE_NONE 3'h0
`define MODE_USER 3'h1
`define MODE_STD 3'h2
`define MODE_SEL 3'h3
`define MODE_RSVD 3'h4
// User key decisions
`define KEY_TO_STD 2'h0
`define KEY_UART_ONLY 2'h1
`define KEY_CAN_ONLY 2'h2
`define KEY_LOOP 2'h3
// Channel codes
`define CHAN_NONE 2'h0
`define CHAN_UART 2'h1
`define CHAN_CAN 2'h2
// Flash word addresses of the reserved locations
`define SIG_WORD_A_ADDR 2'h0
`define SIG_WORD_B_ADDR 2'h1
`define KEY_WORD_ADDR 2'h2
// Start address of both flash maps
`define MAP_BASE_ADDR 24'h000000
`endif

// file: sync2.v
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // sync2
`default_nettype wire

// file: start_detect.v
// Glitch filtered falling edge detector for an idle-high receive line
`timescale 1ns/1ps
`default_nettype none
module start_detect #(
  parameter FILT = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Synchronised line and result
  input wire line,
  input wire arm,
  output reg seen
);
  reg [7:0] low_cnt_q;
  reg idle_q;

  // Line must be seen idle high before a low counts as a start
  always @(posedge clk) begin
    if (rst || !arm) begin
      low_cnt_q <= 8'h00;
      idle_q <= 1'b0;
      seen <= 1'b0;
    end else if (line) begin
      low_cnt_q <= 8'h00;
      idle_q <= 1'b1;
    end else if (idle_q && !seen) begin
      low_cnt_q <= low_cnt_q + 8'h01;
      // Short pulses rejected as noise
      if (low_cnt_q == FILT[7:0] - 8'h01)
        seen <= 1'b1;
    end
  end
endmodule // start_detect
`default_nettype wire

// file: boot_mode_selector.v
// Reset-time boot mode selection and bootstrap channel arbitration
`timescale 1ns/1ps
`default_nettype none
`include "boot_sel_regs.vh"
// What this block does
// - Latch boot pins at reset input rise
// - Pair 11: user mode, user flash fetch
// - Pair 10: standard loader, test flash fetch
// - Pair 01: selective boot, test flash fetch
// - Compute signature, compare with reference
// - Signature good: software reset, run user
// - Signature bad: reread key, choose channel
// - Key: loader, UART, CAN or loop
// - Poll UART and CAN receive lines
// - UART start first: run UART loader
// - CAN dominant first: run CAN loader
module boot_mode_selector #(
  parameter SIG_REF = 16'h0000,
  parameter UART_FILT = 4,
  parameter CAN_FILT = 4
) (
  // Clock and reset
  input wire MCLK,
  input wire RESET,
  // Reset configuration pins
  input wire RESET_INPUT_PIN,
  input wire BOOT_CFG_PIN_HIGH,
  input wire BOOT_CFG_PIN_LOW,
  // Receive lines
  input wire UART0_RECEIVE_LINE,
  input wire CAN1_RECEIVE_LINE,
  // Reserved flash word read port
  output reg FLASH_RD,
  output reg [1:0] FLASH_ADDR,
  input wire [15:0] FLASH_RDATA,
  input wire FLASH_RVALID,
  // Memory map control
  output reg FETCH_TEST_FLASH,
  output reg USER_FLASH_READ_EN,
  output reg [23:0] MAP_BASE,
  // Boot status
  output reg [2:0] BOOT_MODE,
  output reg SIG_VALID,
  output reg SIG_DONE,
  output reg SOFT_RESET,
  output reg RUN_USER,
  output reg [1:0] LOADER_CHAN,
  output reg LOADER_START,
  output reg ENDLESS_LOOP
);
  // Sequencer states, binary coded
  localparam ST_WAIT_RST = 4'h0;
  localparam ST_DECODE = 4'h1;
  localparam ST_RD_A = 4'h2;
  localparam ST_RD_B = 4'h3;
  localparam ST_CHECK = 4'h4;
  localparam ST_RD_KEY = 4'h5;
  localparam ST_POLL = 4'h6;
  localparam ST_DONE = 4'h7;
  localparam ST_LOOP = 4'h8;

  // Synchronised pins and detector results
  wire rst_pin_s;
  wire cfg_hi_s;
  wire cfg_lo_s;
  wire uart_s;
  wire can_s;
  wire uart_seen;
  wire can_seen;
  // Sequencer state and values held across cycles
  reg [3:0] state_q;
  reg rst_pin_prev_q;
  reg [1:0] pair_q;
  reg [15:0] word_a_q;
  reg poll_uart_q;
  reg poll_can_q;
  wire rst_rise;

  // Signature: sum of the two reserved words
  function [15:0] signature;
    input [15:0] a;
    input [15:0] b;
    begin
      signature = a + b;
    end
  endfunction

  // Pins come from outside the clock domain
  sync2 #(.WIDTH(5)) pin_sync (
    .clk(MCLK),
    .rst(RESET),
    .din({RESET_INPUT_PIN, BOOT_CFG_PIN_HIGH, BOOT_CFG_PIN_LOW,
          UART0_RECEIVE_LINE, CAN1_RECEIVE_LINE}),
    .dout({rst_pin_s, cfg_hi_s, cfg_lo_s, uart_s, can_s})
  );

  // UART start bit is a filtered falling edge
  start_detect #(.FILT(UART_FILT)) uart_det (
    .clk(MCLK),
    .rst(RESET),
    .line(uart_s),
    .arm(poll_uart_q),
    .seen(uart_seen)
  );

  // CAN dominant bit is a filtered low level after recessive
  start_detect #(.FILT(CAN_FILT)) can_det (
    .clk(MCLK),
    .rst(RESET),
    .line(can_s),
    .arm(poll_can_q),
    .seen(can_seen)
  );

  // Rise of the synchronised reset pin starts a selection
  assign rst_rise = rst_pin_s && !rst_pin_prev_q;

  // Reset pin edge tracker; a pin held high at RESET needs a fresh rise
  always @(posedge MCLK) begin
    if (RESET)
      rst_pin_prev_q <= 1'b1;
    else
      rst_pin_prev_q <= rst_pin_s;
  end

  // Boot sequencer
  always @(posedge MCLK) begin
    if (RESET) begin
      state_q <= ST_WAIT_RST;
      pair_q <= `BOOT_PAIR_RSVD;
      word_a_q <= 16'h0000;
      poll_uart_q <= 1'b0;
      poll_can_q <= 1'b0;
      FLASH_RD <= 1'b0;
      FLASH_ADDR <= `SIG_WORD_A_ADDR;
      FETCH_TEST_FLASH <= 1'b0;
      USER_FLASH_READ_EN <= 1'b0;
      MAP_BASE <= `MAP_BASE_ADDR;
      BOOT_MODE <= `MODE_NONE;
      SIG_VALID <= 1'b0;
      SIG_DONE <= 1'b0;
      SOFT_RESET <= 1'b0;
      RUN_USER <= 1'b0;
      LOADER_CHAN <= `CHAN_NONE;
      LOADER_START <= 1'b0;
      ENDLESS_LOOP <= 1'b0;
    end else begin
      FLASH_RD <= 1'b0;
      SOFT_RESET <= 1'b0;
      LOADER_START <= 1'b0;
      // A new reset pin low phase restarts the whole selection
      if (!rst_pin_s) begin
        state_q <= ST_WAIT_RST;
        poll_uart_q <= 1'b0;
        poll_can_q <= 1'b0;
        RUN_USER <= 1'b0;
        ENDLESS_LOOP <= 1'b0;
        LOADER_CHAN <= `CHAN_NONE;
        SIG_DONE <= 1'b0;
        SIG_VALID <= 1'b0;
        BOOT_MODE <= `MODE_NONE;
      end else begin
        case (state_q)
          ST_WAIT_RST: begin
            if (rst_rise) begin
              pair_q <= {cfg_hi_s, cfg_lo_s};
              state_q <= ST_DECODE;
            end
          end
          ST_DECODE: begin
            // Both maps start at the base address
            MAP_BASE <= `MAP_BASE_ADDR;
            case (pair_q)
              `BOOT_PAIR_USER: begin
                BOOT_MODE <= `MODE_USER;
                FETCH_TEST_FLASH <= 1'b0;
                USER_FLASH_READ_EN <= 1'b1;
                RUN_USER <= 1'b1;
                state_q <= ST_DONE;
              end
              `BOOT_PAIR_STD: begin
                BOOT_MODE <= `MODE_STD;
                FETCH_TEST_FLASH <= 1'b1;
                USER_FLASH_READ_EN <= 1'b1;
                poll_uart_q <= 1'b1;
                poll_can_q <= 1'b1;
                state_q <= ST_POLL;
              end
              `BOOT_PAIR_SEL: begin
                BOOT_MODE <= `MODE_SEL;
                FETCH_TEST_FLASH <= 1'b1;
                USER_FLASH_READ_EN <= 1'b1;
                FLASH_RD <= 1'b1;
                FLASH_ADDR <= `SIG_WORD_A_ADDR;
                state_q <= ST_RD_A;
              end
              default: begin
                BOOT_MODE <= `MODE_RSVD;
                FETCH_TEST_FLASH <= 1'b0;
                USER_FLASH_READ_EN <= 1'b0;
                state_q <= ST_DONE;
              end
            endcase
          end
          ST_RD_A: begin
            // Word A is kept until word B arrives
            if (FLASH_RVALID) begin
              word_a_q <= FLASH_RDATA;
              FLASH_RD <= 1'b1;
              FLASH_ADDR <= `SIG_WORD_B_ADDR;
              state_q <= ST_RD_B;
            end
          end
          ST_RD_B: begin
            if (FLASH_RVALID) begin
              SIG_DONE <= 1'b1;
              SIG_VALID <= (signature(word_a_q, FLASH_RDATA) == SIG_REF);
              state_q <= ST_CHECK;
            end
          end
          ST_CHECK: begin
            if (SIG_VALID) begin
              SOFT_RESET <= 1'b1;
              FETCH_TEST_FLASH <= 1'b0;
              RUN_USER <= 1'b1;
              state_q <= ST_DONE;
            end else begin
              FLASH_RD <= 1'b1;
              FLASH_ADDR <= `KEY_WORD_ADDR;
              state_q <= ST_RD_KEY;
            end
          end
          ST_RD_KEY: begin
            // Only the two low key bits are decoded
            // Key selects four outcomes
            if (FLASH_RVALID) begin
              case (FLASH_RDATA[1:0])
                `KEY_TO_STD: begin
                  // Same polling as the standard loader
                  poll_uart_q <= 1'b1;
                  poll_can_q <= 1'b1;
                  state_q <= ST_POLL;
                end
                `KEY_UART_ONLY: begin
                  poll_uart_q <= 1'b1;
                  state_q <= ST_POLL;
                end
                `KEY_CAN_ONLY: begin
                  poll_can_q <= 1'b1;
                  state_q <= ST_POLL;
                end
                default: begin
                  ENDLESS_LOOP <= 1'b1;
                  state_q <= ST_LOOP;
                end
              endcase
            end
          end
          ST_POLL: begin
            // UART wins a tie; loader is the legacy one
            if (uart_seen) begin
              LOADER_CHAN <= `CHAN_UART;
              LOADER_START <= 1'b1;
              poll_uart_q <= 1'b0;
              poll_can_q <= 1'b0;
              state_q <= ST_DONE;
            end else if (can_seen) begin
              LOADER_CHAN <= `CHAN_CAN;
              LOADER_START <= 1'b1;
              poll_uart_q <= 1'b0;
              poll_can_q <= 1'b0;
              state_q <= ST_DONE;
            end
          end
          ST_DONE: begin
            // Outcome holds until the reset pin drops
            state_q <= ST_DONE;
          end
          ST_LOOP: begin
            // Only a new reset leaves the loop
            state_q <= ST_LOOP;
          end
          default: begin
            state_q <= ST_WAIT_RST;
          end
        endcase
      end
    end
  end
  // Limitation: map bits keep their last decode while the reset pin is low
endmodule // boot_mode_selector
`default_nettype wire

// file: boot_mode_selector_chk.sv
// Assertion checker for the boot mode selector
`timescale 1ns/1ps
`default_nettype none
module boot_mode_selector_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  // Watched ports
  input wire logic RESET_INPUT_PIN,
  input wire logic FLASH_RD,
  input wire logic [1:0] FLASH_ADDR,
  input wire logic FETCH_TEST_FLASH,
  input wire logic USER_FLASH_READ_EN,
  input wire logic [2:0] BOOT_MODE,
  input wire logic SIG_VALID,
  input wire logic SIG_DONE,
  input wire logic SOFT_RESET,
  input wire logic RUN_USER,
  input wire logic [1:0] LOADER_CHAN,
  input wire logic LOADER_START,
  input wire logic ENDLESS_LOOP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Decode follows the pin rise after the sync delay, within six cycles
  property p_cap; $rose(RESET_INPUT_PIN) |-> ##[1:6] BOOT_MODE != 3'h0; endproperty
  a_cap: assert property (p_cap) else $error("no decode after pin rise");
  property p_user; BOOT_MODE == 3'h1 |-> !FETCH_TEST_FLASH && USER_FLASH_READ_EN; endproperty
  a_user: assert property (p_user) else $error("user map wrong");
  property p_std; BOOT_MODE == 3'h2 |-> FETCH_TEST_FLASH && USER_FLASH_READ_EN; endproperty
  a_std: assert property (p_std) else $error("loader map wrong");
  // Selective boot starts with the first signature word
  property p_sel;
    $changed(BOOT_MODE) && BOOT_MODE == 3'h3 |-> FETCH_TEST_FLASH && FLASH_RD && FLASH_ADDR == 2'h0;
  endproperty
  a_sel: assert property (p_sel) else $error("selective start wrong");
  property p_good;
    $rose(SIG_DONE) && SIG_VALID |=> SOFT_RESET && RUN_USER && !FETCH_TEST_FLASH;
  endproperty
  a_good: assert property (p_good) else $error("good signature path wrong");
  property p_bad; $rose(SIG_DONE) && !SIG_VALID |=> FLASH_RD && FLASH_ADDR == 2'h2; endproperty
  a_bad: assert property (p_bad) else $error("key not reread");
  // Start is a single pulse with a channel named
  property p_start; LOADER_START |-> LOADER_CHAN != 2'h0 ##1 !LOADER_START; endproperty
  a_start: assert property (p_start) else $error("loader start wrong");
  property p_rsvd; BOOT_MODE == 3'h4 |-> !FLASH_RD && !LOADER_START && !RUN_USER; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved pair acted");
  c_good: cover property (SOFT_RESET);
  c_loop: cover property ($rose(ENDLESS_LOOP));
  c_can: cover property (LOADER_START && LOADER_CHAN == 2'h2);
endmodule // boot_mode_selector_chk
bind boot_mode_selector boot_mode_selector_chk boot_mode_selector_chk_i (
  .MCLK(MCLK), .RESET(RESET), .RESET_INPUT_PIN(RESET_INPUT_PIN),
  .FLASH_RD(FLASH_RD), .FLASH_ADDR(FLASH_ADDR), .FETCH_TEST_FLASH(FETCH_TEST_FLASH),
  .USER_FLASH_READ_EN(USER_FLASH_READ_EN), .BOOT_MODE(BOOT_MODE), .SIG_VALID(SIG_VALID),
  .SIG_DONE(SIG_DONE), .SOFT_RESET(SOFT_RESET), .RUN_USER(RUN_USER),
  .LOADER_CHAN(LOADER_CHAN), .LOADER_START(LOADER_START), .ENDLESS_LOOP(ENDLESS_LOOP)
);
`default_nettype wire

// file: host_model.sv
// Flash word store and host receive lines facing the selector
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk,
  // Flash word port
  input wire logic rd,
  input wire logic [1:0] addr,
  input wire logic [15:0] word_a,
  input wire logic [15:0] word_b,
  input wire logic [15:0] word_k,
  input wire logic [3:0] lat,
  output logic rvalid,
  output logic [15:0] rdata,
  // Host activity
  input wire logic uart_go,
  input wire logic can_go,
  output wire logic uart_line,
  output wire logic can_line
);
  logic busy_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] addr_q = 2'h0;
  initial rvalid = 1'b0;
  initial rdata = 16'h0;
  // reserved words served
  // Data flips after the pulse so stale words never match
  always @(posedge clk) begin
    rvalid <= 1'b0;
    if (rvalid)
      rdata <= ~rdata;
    if (rd) begin
      busy_q <= 1'b1;
      cnt_q <= lat;
      addr_q <= addr;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      rvalid <= 1'b1;
      rdata <= addr_q == 2'h0 ? word_a : (addr_q == 2'h1 ? word_b : word_k);
    end
  end
  // Pull-ups keep both lines high when idle
  assign uart_line = !uart_go;
  assign can_line = !can_go;
endmodule // host_model
`default_nettype wire

// file: boot_mode_selector_test.sv
// Self-checking bench for the boot mode selector
`timescale 1ns/1ps
`default_nettype none
module boot_mode_selector_test;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic pin = 1'b0;
  logic ch = 1'b0;
  logic cl = 1'b0;
  logic ug = 1'b0;
  logic cg = 1'b0;
  logic [3:0] lat = 4'h2;
  logic [15:0] wa = 16'h0;
  logic [15:0] wb = 16'h0;
  logic [15:0] wk = 16'h0;
  int miscompares = 0;
  int samples_checked = 0;
  wire rd, rv, fts, ure, sv, sd, sr, ru, ls, el, ul, cnl;
  wire [1:0] fa, chan;
  wire [15:0] rdat;
  wire [23:0] mb;
  wire [2:0] mode;
  // Clock at 200 MHz
  always #2.5 MCLK = ~MCLK;
  boot_mode_selector boot_mode_selector_i (.MCLK(MCLK), .RESET(RESET),
    .RESET_INPUT_PIN(pin), .BOOT_CFG_PIN_HIGH(ch), .BOOT_CFG_PIN_LOW(cl),
    .UART0_RECEIVE_LINE(ul), .CAN1_RECEIVE_LINE(cnl), .FLASH_RD(rd), .FLASH_ADDR(fa),
    .FLASH_RDATA(rdat), .FLASH_RVALID(rv), .FETCH_TEST_FLASH(fts), .USER_FLASH_READ_EN(ure),
    .MAP_BASE(mb), .BOOT_MODE(mode), .SIG_VALID(sv), .SIG_DONE(sd), .SOFT_RESET(sr),
    .RUN_USER(ru), .LOADER_CHAN(chan), .LOADER_START(ls), .ENDLESS_LOOP(el));
  host_model host_model_i (.clk(MCLK), .rd(rd), .addr(fa), .word_a(wa), .word_b(wb),
    .word_k(wk), .lat(lat), .rvalid(rv), .rdata(rdat), .uart_go(ug), .can_go(cg),
    .uart_line(ul), .can_line(cnl));
  task automatic wrap_up;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bounded wait for decode (m) or for a final boot outcome
  task automatic wait_for(input bit m);
    int n;
    n = 0;
    while ((m ? mode === 3'h0 : !(ls === 1'b1 || ru === 1'b1 || el === 1'b1)) && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      miscompares++;
      wrap_up;
    end
  endtask
  // Pin low clears, then a fresh rise latches the pair
  task automatic boot(input logic [1:0] p);
    ug = 1'b0;
    cg = 1'b0;
    pin = 1'b0;
    {ch, cl} = p;
    tick(3);
    pin = 1'b1;
    wait_for(1'b1);
  endtask
  task automatic t_user;
    boot(2'h3);
    chk(16'(mode), 16'h1);
    chk({14'h0, fts, ure}, 16'h1);
    chk(mb[15:0] | mb[23:8], 16'h0);
    {ch, cl} = 2'h0;
    tick(8);
    chk(16'(mode), 16'h1);
  endtask
  task automatic t_std(input bit uart, input logic [1:0] ec);
    boot(2'h2);
    chk({13'h0, mode, fts, ure}, 16'h0b);
    tick(10);
    chk({14'h0, chan}, 16'h0);
    ug = uart;
    cg = !uart;
    wait_for(1'b0);
    chk({13'h0, ls, chan}, {13'h0, 1'b1, ec});
  endtask
  task automatic t_sel(input logic [15:0] a, input logic [15:0] k, input logic [1:0] go,
    input logic [3:0] ec, input logic [1:0] ech);
    wa = a;
    wb = 16'hedcc;
    wk = k;
    boot(2'h1);
    chk({13'h0, mode, fts}, 16'h7);
    tick(40);
    // Host activity: go holds the UART and CAN drive levels
    {ug, cg} = go;
    wait_for(1'b0);
    chk({11'h0, sd, sv, ru, el, ls}, {11'h0, 1'b1, ec});
    chk({14'h0, chan}, {14'h0, ech});
  endtask
  initial begin
    tick(12);
    RESET = 1'b0;
    tick(2);
    t_user;
    t_std(1'b1, 2'h1);
    t_std(1'b0, 2'h2);
    lat = 4'h9;
    // Sum wraps to the zero reference
    t_sel(16'h1234, 16'h0000, 2'h3, 4'hc, 2'h0);
    lat = 4'h0;
    // Key 0 polls both lines; only CAN is active here
    t_sel(16'h0001, 16'h0000, 2'h1, 4'h1, 2'h2);
    t_sel(16'h0001, 16'h0001, 2'h3, 4'h1, 2'h1);
    // CAN only: the active UART line is ignored
    t_sel(16'h0001, 16'h0002, 2'h3, 4'h1, 2'h2);
    t_sel(16'h0001, 16'h0003, 2'h3, 4'h2, 2'h0);
    boot(2'h0);
    tick(20);
    chk({9'h0, mode, fts, ru, ls, el}, 16'h40);
    wrap_up;
  end
endmodule // boot_mode_selector_test
`default_nettype wire
